// ===== rtl/trunking_message_encoder.sv
// trunking message encoder with axi4-lite registers and serial output
`timescale 1ns/10ps
module trunking_message_encoder
   import msg_enc_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic        clk,           // 200 MHz clock
   input  wire logic        srst,          // sync reset, high
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // byte enables
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   output logic             mod_active,    // modulation path driven
   output logic             mod_pos,       // level positive when high
   output logic             mod_neg        // level negative when high
);
   import msg_enc_pkg::*;

   if (FIFO_DEPTH != 8) begin : g_depth_chk
      $error("encoder fifo depth fixed at 8");
   end

   typedef enum logic [1:0] {IDLE, RUN, DRAIN} seq_t;

   // crc over one bit, shared by framer
   function automatic logic [6:0] crc_step(input logic [6:0] c, input logic b);
      logic fb;
      fb = c[6] ^ b;
      crc_step = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
   endfunction

   // ---------------- registers ----------------
   logic [7:0]         ctrl_r;
   logic [31:0]        rate_r;
   logic [15:0]        burst_r;
   logic [FIELD_W-1:0] msg0_r;
   logic [FIELD_W-1:0] msg1_r;
   logic [7:0]         awaddr_r;
   logic               aw_have_r;
   logic [31:0]        wdata_r;
   logic [3:0]         wstrb_r;
   logic               w_have_r;
   logic               bvalid_r;
   logic [1:0]         bresp_r;
   logic               rvalid_r;
   logic [31:0]        rdata_r;
   logic [1:0]         rresp_r;

   // write channels taken independently, either order
   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   wire wr_go = aw_have_r && w_have_r && !bvalid_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         if (s[i]) old[i*8 +: 8] = d[i*8 +: 8];
      end
      merge = old;
   endfunction

   wire [31:0] wmerge_ctrl  = merge({24'h0, ctrl_r}, wdata_r, wstrb_r);
   wire [31:0] wmerge_rate  = merge(rate_r, wdata_r, wstrb_r);
   wire [31:0] wmerge_burst = merge({16'h0, burst_r}, wdata_r, wstrb_r);
   wire [31:0] wmerge_m0    = merge({8'h0, msg0_r}, wdata_r, wstrb_r);
   wire [31:0] wmerge_m1    = merge({8'h0, msg1_r}, wdata_r, wstrb_r);
   wire        wr_ctrl  = wr_go && (awaddr_r == CTRL_OFS);
   wire        wr_cmd   = wr_go && (awaddr_r == CMD_OFS);
   wire        wr_rate  = wr_go && (awaddr_r == RATE_OFS);
   wire        wr_burst = wr_go && (awaddr_r == BURST_OFS);
   wire        wr_m0    = wr_go && (awaddr_r == MSG0_OFS);
   wire        wr_m1    = wr_go && (awaddr_r == MSG1_OFS);
   wire        wr_known = wr_ctrl | wr_cmd | wr_rate | wr_burst | wr_m0 | wr_m1;
   wire        cmd_send = wr_cmd && wstrb_r[0] && wdata_r[SEND_BIT];
   wire        cmd_stop = wr_cmd && wstrb_r[0] && wdata_r[STOP_BIT];

   // write path capture and response
   always_ff @(posedge clk) begin
      if (srst) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= AXI_OKAY;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_known ? AXI_OKAY : AXI_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // software registers; writable while running
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r  <= 8'h00;
         rate_r  <= RATE_RST;
         burst_r <= BURST_RST;
         msg0_r  <= '0;
         msg1_r  <= '0;
      end else begin
         if (wr_ctrl) ctrl_r <= wmerge_ctrl[7:0];
         if (wr_rate) rate_r <= (wmerge_rate == 32'h0) ? 32'h00000001 : wmerge_rate;
         if (wr_burst) burst_r <= wmerge_burst[15:0];
         if (wr_m0) msg0_r <= wmerge_m0[FIELD_W-1:0];
         if (wr_m1) msg1_r <= wmerge_m1[FIELD_W-1:0];
      end
   end

   // ---------------- bit rate enable ----------------
   // phase accumulator: rate in centi-bps against 100*clock; slight jitter, no drift
   localparam logic [39:0] ACC_MOD = 40'(CLK_HZ * 100);
   logic [39:0] acc_r;
   wire  [39:0] acc_sum = acc_r + {8'h00, rate_r};
   wire         bit_tick = (acc_sum >= ACC_MOD);
   always_ff @(posedge clk) begin
      if (srst) acc_r <= 40'h0;
      else acc_r <= bit_tick ? acc_sum - ACC_MOD : acc_sum;
   end

   // ---------------- framer ----------------
   seq_t               seq_r;
   logic [5:0]         fpos_r;
   logic [FIELD_W-1:0] fld_r;
   logic [6:0]         crc_r;
   logic [15:0]        left_r;
   logic               stop_r;
   logic [1:0]         mode_run_r;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic               fifo_out_data;
   logic               line_busy_r;
   logic               line_bit_r;

   wire [1:0] mode_sel = ctrl_r[MODE_LSB +: MODE_W];
   wire       sel_msg  = ctrl_r[SEL_BIT];
   wire [FIELD_W-1:0] cur_fields = sel_msg ? msg1_r : msg0_r;
   wire       start_ok = cmd_send && (mode_sel != MODE_STEP)
                         && !(mode_sel == MODE_BURST && burst_r == 16'h0);
   // bit being produced at this frame position
   wire       in_sync  = (fpos_r < 6'(SYNC_W));
   wire       in_check = (fpos_r >= 6'(SYNC_W + FIELD_W));
   wire [5:0] chk_idx  = 6'(FRAME_W - 1) - fpos_r;
   wire [5:0] syn_idx  = 6'(SYNC_W - 1) - fpos_r;
   wire       gen_bit  = in_sync ? SYNC_PAT[syn_idx[3:0]] :
                         in_check ? crc_r[chk_idx[2:0]] : fld_r[0];
   wire       push     = (seq_r == RUN) && fifo_in_ready;
   wire       last_bit = (fpos_r == 6'(FRAME_W - 1));
   wire       more     = !stop_r && !cmd_stop &&
                         ((mode_run_r == MODE_CONT) ||
                          (mode_run_r == MODE_BURST && left_r > 16'h1));

   // frame sequencing: fields latched at each frame start
   always_ff @(posedge clk) begin
      if (srst) begin
         seq_r      <= IDLE;
         fpos_r     <= 6'h0;
         fld_r      <= '0;
         crc_r      <= 7'h00;
         left_r     <= 16'h0;
         stop_r     <= 1'b0;
         mode_run_r <= MODE_SINGLE;
      end else begin
         case (seq_r)
            IDLE: begin
               stop_r <= 1'b0;
               if (start_ok) begin
                  seq_r      <= RUN;
                  fpos_r     <= 6'h0;
                  fld_r      <= cur_fields;
                  crc_r      <= 7'h00;
                  mode_run_r <= mode_sel;
                  left_r     <= (mode_sel == MODE_BURST) ? burst_r : 16'h1;
               end
            end
            RUN: begin
               if (cmd_stop) stop_r <= 1'b1;
               if (push) begin
                  if (!in_sync && !in_check) begin
                     fld_r <= {1'b0, fld_r[FIELD_W-1:1]};
                     crc_r <= crc_step(crc_r, fld_r[0]);
                  end
                  if (last_bit) begin
                     fpos_r <= 6'h0;
                     crc_r  <= 7'h00;
                     left_r <= left_r - 16'h1;
                     if (more) fld_r <= cur_fields;
                     else seq_r <= DRAIN;
                  end else begin
                     fpos_r <= fpos_r + 6'h1;
                  end
               end
            end
            DRAIN: begin
               if (!fifo_out_valid && !line_busy_r) seq_r <= IDLE;
            end
            default: seq_r <= IDLE;
         endcase
      end
   end

   bit_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .flush     (1'b0),
      .in_data   (gen_bit),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (bit_tick)
   );

   // line stage: one bit per rate tick, idles when fifo empty
   always_ff @(posedge clk) begin
      if (srst) begin
         line_busy_r <= 1'b0;
         line_bit_r  <= 1'b0;
      end else if (bit_tick) begin
         line_busy_r <= fifo_out_valid;
         line_bit_r  <= fifo_out_valid ? fifo_out_data : 1'b0;
      end
   end

   // polarity applied at the output so it can change live
   wire pol_inv = ctrl_r[POL_BIT];
   always_ff @(posedge clk) begin
      if (srst) begin
         mod_active <= 1'b0;
         mod_pos    <= 1'b0;
         mod_neg    <= 1'b0;
      end else begin
         mod_active <= line_busy_r;
         mod_pos    <= line_busy_r && (line_bit_r ^ pol_inv);
         mod_neg    <= line_busy_r && !(line_bit_r ^ pol_inv);
      end
   end

   // ---------------- read path ----------------
   wire [31:0] stat_word = {28'h0, stop_r, (seq_r == DRAIN), (seq_r == RUN), line_busy_r};
   wire [31:0] rd_mux =
      (s_axi_araddr == CTRL_OFS)  ? {24'h0, ctrl_r} :
      (s_axi_araddr == RATE_OFS)  ? rate_r :
      (s_axi_araddr == BURST_OFS) ? {16'h0, burst_r} :
      (s_axi_araddr == MSG0_OFS)  ? {8'h0, msg0_r} :
      (s_axi_araddr == MSG1_OFS)  ? {8'h0, msg1_r} :
      (s_axi_araddr == STAT_OFS)  ? stat_word : 32'h00000000;
   wire rd_known = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == RATE_OFS) ||
                   (s_axi_araddr == BURST_OFS) || (s_axi_araddr == MSG0_OFS) ||
                   (s_axi_araddr == MSG1_OFS) || (s_axi_araddr == STAT_OFS) ||
                   (s_axi_araddr == CMD_OFS);
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_known ? AXI_OKAY : AXI_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------- checks ----------------
   a_pol_excl: assert property (@(posedge clk) disable iff (srst)
      !(mod_pos && mod_neg)) else $error("both levels driven");
   a_idle_quiet: assert property (@(posedge clk) disable iff (srst)
      !mod_active |-> !mod_pos && !mod_neg) else $error("level while idle");
   a_step_none: assert property (@(posedge clk) disable iff (srst)
      (seq_r == IDLE && cmd_send && mode_sel == MODE_STEP) |=> seq_r == IDLE)
      else $error("step mode started");
   a_send_runs: assert property (@(posedge clk) disable iff (srst)
      (seq_r == IDLE && start_ok) |=> seq_r == RUN) else $error("send ignored");
   a_single_one: assert property (@(posedge clk) disable iff (srst)
      (push && last_bit && mode_run_r == MODE_SINGLE) |=> seq_r == DRAIN)
      else $error("single repeated");
   a_stop_ends: assert property (@(posedge clk) disable iff (srst)
      (push && last_bit && stop_r) |=> seq_r == DRAIN) else $error("ran past stop");
   a_cont_rep: assert property (@(posedge clk) disable iff (srst)
      (push && last_bit && mode_run_r == MODE_CONT && !stop_r && !cmd_stop)
      |=> seq_r == RUN && fpos_r == 6'h0) else $error("continuous ended");
   a_burst_cnt: assert property (@(posedge clk) disable iff (srst)
      (seq_r == RUN && push && last_bit) |=> left_r == $past(left_r) - 16'h1)
      else $error("burst count slip");
   a_rate_rst: assert property (@(posedge clk)
      $past(srst) |-> rate_r == RATE_RST) else $error("rate reset wrong");
   a_sync_bit: assert property (@(posedge clk) disable iff (srst)
      (push && fpos_r == 6'h0) |-> gen_bit == SYNC_PAT[8]) else $error("sync order");
   c_single: cover property (@(posedge clk) seq_r == RUN && mode_run_r == MODE_SINGLE);
   c_burst: cover property (@(posedge clk) push && last_bit && mode_run_r == MODE_BURST && more);
   c_stop: cover property (@(posedge clk) seq_r == RUN && cmd_stop);
   c_invert: cover property (@(posedge clk) mod_active && pol_inv);
endmodule // trunking_message_encoder

// ===== rtl/msg_enc_pkg.sv
// constants shared by the trunking message encoder files
package msg_enc_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] CMD_OFS    = 8'h04;
   localparam logic [7:0] RATE_OFS   = 8'h08;
   localparam logic [7:0] BURST_OFS  = 8'h0C;
   localparam logic [7:0] MSG0_OFS   = 8'h10;
   localparam logic [7:0] MSG1_OFS   = 8'h14;
   localparam logic [7:0] STAT_OFS   = 8'h18;
   // control fields
   localparam int SEL_BIT   = 0;
   localparam int POL_BIT   = 1;
   localparam int MODE_LSB  = 4;
   localparam int MODE_W    = 2;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_BURST  = 2'h1;
   localparam logic [1:0] MODE_CONT   = 2'h2;
   localparam logic [1:0] MODE_STEP   = 2'h3;
   // command bits
   localparam int SEND_BIT = 0;
   localparam int STOP_BIT = 1;
   // message word layout: area[0], goto[5:1], home[10:6], ident[18:11], free[23:19]
   localparam int AREA_POS  = 0;
   localparam int GOTO_POS  = 1;
   localparam int HOME_POS  = 6;
   localparam int IDENT_POS = 11;
   localparam int FREE_POS  = 19;
   localparam int FIELD_W   = 24;
   // frame layout
   localparam int SYNC_W  = 9;
   localparam int CHECK_W = 7;
   localparam int FRAME_W = SYNC_W + FIELD_W + CHECK_W;
   localparam logic [8:0] SYNC_PAT = 9'h158;
   localparam logic [6:0] CRC_POLY = 7'h09;
   // timing: rate in centi-bits per second, clock 200 MHz
   localparam longint CLK_HZ      = 200000000;
   localparam logic [31:0] RATE_RST = 32'h00007440; // 297.60 bit/s
   localparam logic [15:0] BURST_RST = 16'h0001;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== rtl/bit_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,      // system clock
   input  wire logic             srst,     // sync reset
   input  wire logic             flush,    // drop contents
   input  wire logic [WIDTH-1:0] in_data,  // write data
   input  wire logic             in_valid, // write request
   output logic                  in_ready, // room available
   output logic [WIDTH-1:0]      out_data, // head word
   output logic                  out_valid,// head valid
   input  wire logic             out_ready // drain
);
   localparam int AW = $clog2(DEPTH);
   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
      $error("bit_fifo depth must be power of two");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;
   // honest flags from the occupancy count
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   // pointer and count update
   always_ff @(posedge clk) begin
      if (srst || flush) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // storage write
   always_ff @(posedge clk) begin
      if (push) mem_r[wp_r] <= in_data;
   end
endmodule // bit_fifo

// ===== tb/radio_rx_model.sv
// receiving radio model: samples modulation levels into 40-bit frames
`timescale 1ns/10ps
module radio_rx_model #(
   parameter int BIT_CYC = 20
) (
   input  wire logic        clk,        // system clock
   input  wire logic        mod_active, // line driven
   input  wire logic        mod_pos,    // positive level
   input  wire logic        mod_neg,    // negative level
   output logic             frame_stb,  // one cycle per frame
   output logic [39:0]      frame_lvl,  // levels, first bit in msb
   output logic             lvl_err     // both or neither level seen
);
   int unsigned nfr   = 0;
   int unsigned nseen = 0;
   int          cnt;
   logic [39:0] sh;
   initial begin
      frame_lvl = '0;
      lvl_err   = 1'b0;
   end
   // sample mid-bit; a partial frame is dropped when the line idles
   always begin
      @(posedge clk iff mod_active === 1'b1);
      cnt = 0;
      repeat (BIT_CYC / 2) @(posedge clk);
      while (mod_active === 1'b1) begin
         if (mod_pos === mod_neg) lvl_err = 1'b1;
         sh = {sh[38:0], mod_pos};
         cnt++;
         if (cnt == 40) begin
            frame_lvl = sh;
            nfr++;
            cnt = 0;
         end
         repeat (BIT_CYC) @(posedge clk);
      end
   end
   // strobe per finished frame, kept apart from the sampling loop
   always @(posedge clk) begin
      frame_stb <= (nfr != nseen);
      nseen     <= nfr;
   end
endmodule // radio_rx_model

// ===== tb/tb.sv
// self-checking bench for the trunking message encoder
`timescale 1ns/10ps
module tb;
   import msg_enc_pkg::*;
   localparam int          BIT_CYC   = 20;
   localparam logic [31:0] FAST_RATE = 32'h3B9ACA00; // 20 clocks per bit
   logic        clk, srst, mod_active, mod_pos, mod_neg, frame_stb, lvl_err;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [39:0] frame_lvl;
   logic [39:0] exp_q[$];
   logic [23:0] msg[2];
   logic [31:0] seed = 32'h0000B092;
   int          n_mismatch = 0;
   int          samples_checked = 0;

   trunking_message_encoder i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_active, .mod_pos, .mod_neg);
   radio_rx_model #(.BIT_CYC(BIT_CYC)) i_rx (.clk, .mod_active, .mod_pos, .mod_neg,
      .frame_stb, .frame_lvl, .lvl_err);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // expected line levels: sync, fields lsb first, check msb first
   function automatic logic [39:0] frame_of(input logic [23:0] f, input logic inv);
      logic [6:0]  c;
      logic [23:0] r;
      logic        b;
      c = '0;
      for (int i = 0; i < 24; i++) begin
         r[23-i] = f[i];
         b = f[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (b ? CRC_POLY : 7'h00);
      end
      return {SYNC_PAT, r, c} ^ {40{inv}};
   endfunction

   // both channels offered at once, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) begin
         n_mismatch++;
         $display("MISMATCH t=%0t write answer timed out", $time);
      end
      chk(s_axi_bresp, AXI_OKAY);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      int n;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 50) begin
         n_mismatch++;
         $display("MISMATCH t=%0t read answer timed out", $time);
      end
      chk({s_axi_rdata, s_axi_rresp}, {d, rsp});
   endtask

   // note expected frames, then issue send
   task automatic go(input logic [1:0] mode, input logic sel, input logic inv, input int nexp);
      axi_wr(CTRL_OFS, {26'h0, mode, 2'h0, inv, sel});
      repeat (nexp) exp_q.push_back(frame_of(msg[sel], inv));
      axi_wr(CMD_OFS, 32'h00000001);
   endtask

   // wait for all noted frames, then the line must fall idle
   task automatic drain;
      int n;
      for (n = 0; n < 20000 && exp_q.size() != 0; n++) @(posedge clk);
      repeat (4 * BIT_CYC) @(posedge clk);
      chk({exp_q.size() == 0, mod_active, mod_pos, mod_neg}, 40'h8);
   endtask

   // watcher: each frame seen takes the oldest note
   always @(posedge clk) begin
      if (frame_stb === 1'b1) begin
         if (exp_q.size() == 0) chk(frame_lvl, ~frame_lvl);
         else chk(frame_lvl, exp_q.pop_front());
      end
   end

   // watchdog well above the expected span of the run
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude;
   end

   initial begin
      srst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      axi_rd(RATE_OFS, RATE_RST, AXI_OKAY);
      axi_rd(BURST_OFS, {16'h0, BURST_RST}, AXI_OKAY);
      axi_rd(CMD_OFS, 32'h0, AXI_OKAY);
      axi_rd(8'h1C, 32'h0, AXI_SLVERR);
      axi_wr(RATE_OFS, FAST_RATE);
      axi_rd(RATE_OFS, FAST_RATE, AXI_OKAY);
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         msg[i] = seed[23:0];
      end
      msg[0][18:11] = 8'hFF; // idle-channel identity
      axi_wr(MSG0_OFS, {8'h0, msg[0]});
      axi_wr(MSG1_OFS, {8'h0, msg[1]});
      axi_rd(MSG1_OFS, {8'h0, msg[1]}, AXI_OKAY);
      axi_wr(BURST_OFS, 32'h00000003);
      go(MODE_SINGLE, 1'b1, 1'b0, 1);
      drain;
      axi_rd(STAT_OFS, 32'h0, AXI_OKAY);
      go(MODE_BURST, 1'b0, 1'b1, 3);
      drain;
      go(MODE_STEP, 1'b0, 1'b0, 0);
      drain;
      // selection changed mid-run, then stop during the second frame
      go(MODE_CONT, 1'b0, 1'b0, 1);
      exp_q.push_back(frame_of(msg[1], 1'b0));
      repeat (300) @(posedge clk);
      axi_wr(CTRL_OFS, {26'h0, MODE_CONT, 4'h1});
      repeat (850) @(posedge clk);
      axi_wr(CMD_OFS, 32'h00000002);
      drain;
      // a zero count must not start a burst
      axi_wr(BURST_OFS, 32'h00000000);
      go(MODE_BURST, 1'b0, 1'b0, 0);
      drain;
      axi_wr(BURST_OFS, 32'h00000003);
      go(MODE_BURST, 1'b1, 1'b0, 2);
      repeat (1150) @(posedge clk);
      axi_wr(CMD_OFS, 32'h00000002);
      drain;
      chk(lvl_err, 40'h0);
      conclude;
   end
endmodule // tb
